/* csi2_test_pattern_generator.sv */
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module csi2_test_pattern_generator (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// stream to transmitter
	input wire logic i_tx_ready,
	output logic o_tx_valid,
	output logic [1:0] o_tx_kind,
	output logic [15:0] o_tx_data,
	output logic [5:0] o_tx_dt,
	output logic [1:0] o_tx_vc,
	output logic o_tx_last
);
	import pattern_gen_pkg::*;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic [2:0] bars_m1(input logic [1:0] code);
		bars_m1 = 3'((4'h1 << code) - 4'h1);
	endfunction : bars_m1

	// register file
	logic [1:0] ctrl_r;
	logic [1:0] bars_r;
	logic [3:0] blk_r;
	logic [7:0] csi_r;
	logic [15:0] lsize_r, bar_r, act_r, tot_r, pd_r;
	logic [7:0] vbp_r, vfp_r;
	logic [7:0] fix_r [FIX_BYTES];
	logic ack_r;
	logic [31:0] rdata_r;
	// frame shadows
	logic sh_fixed;
	logic [1:0] sh_bars;
	logic [3:0] sh_blk;
	logic [7:0] sh_csi;
	logic [15:0] sh_lsize, sh_bar, sh_act, sh_tot, sh_pd;
	logic [7:0] sh_vbp, sh_vfp;
	logic [7:0] sh_fix [FIX_BYTES];
	// sequencing
	state_e state_r;
	logic [PD_W-1:0] pd_cnt_r;
	logic [15:0] line_idx_r;
	logic pend_r;
	logic [15:0] byte_cnt_r, bar_pos_r;
	logic [2:0] bar_idx_r;
	logic [3:0] blk_idx_r;

	logic req, bus_do, wr_do, fix_sel;
	logic [3:0] fix_idx;
	logic running, tick, frame_start, can_load, load;
	logic [PD_W-1:0] pd_limit, pd_cnt_p1;
	logic [15:0] act_end, fe_slot, line_next;
	logic line_active, line_is_fe, last_byte, bar_end, blk_end;
	logic emit, emit_last;
	logic [1:0] emit_kind;
	logic [15:0] emit_data;
	logic [7:0] pat_byte;

	assign req = i_avs_read | i_avs_write;
	assign bus_do = i_ce & req & ~ack_r;
	assign wr_do = i_ce & i_avs_write & ack_r;
	assign o_avs_waitrequest = ~i_ce | (req & ~ack_r);
	assign o_avs_readdata = rdata_r;
	assign fix_sel = i_avs_address[7:6] == FIX_PAGE;
	assign fix_idx = i_avs_address[5:2];

	// one wait cycle per access
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ack_r <= 1'b0;
		end else if (i_ce) begin
			ack_r <= req & ~ack_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r <= 32'h0;
		end else if (bus_do) begin
			rdata_r <= 32'h0;
			if (fix_sel) begin
				rdata_r[7:0] <= fix_r[fix_idx];
			end else begin
				unique case (i_avs_address)
					OFS_CTRL: rdata_r[1:0] <= ctrl_r;
					OFS_CFG: rdata_r[7:0] <= {blk_r, 2'h0, bars_r};
					OFS_CSI: rdata_r[7:0] <= csi_r;
					OFS_LINE_SIZE: rdata_r[15:0] <= lsize_r;
					OFS_BAR_SIZE: rdata_r[15:0] <= bar_r;
					OFS_ACT_LINES: rdata_r[15:0] <= act_r;
					OFS_TOT_LINES: rdata_r[15:0] <= tot_r;
					OFS_LINE_PD: rdata_r[15:0] <= pd_r;
					OFS_VBP: rdata_r[7:0] <= vbp_r;
					OFS_VFP: rdata_r[7:0] <= vfp_r;
					OFS_STATUS: begin
						rdata_r[STAT_RUN_BIT] <= running;
						rdata_r[STAT_FRAME_BIT] <= state_r != S_WAIT && running;
						rdata_r[STAT_LINE_LSB +: 16] <= line_idx_r;
					end
					default: rdata_r <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_r <= CTRL_RST;
			bars_r <= BARS_RST;
			blk_r <= BLK_RST;
			csi_r <= CSI_RST;
			lsize_r <= WORD16_RST;
			bar_r <= WORD16_RST;
			act_r <= WORD16_RST;
			tot_r <= WORD16_RST;
			pd_r <= WORD16_RST;
			vbp_r <= BYTE_RST;
			vfp_r <= BYTE_RST;
		end else if (wr_do && !fix_sel && i_avs_byteenable[0]) begin
			unique case (i_avs_address)
				OFS_CTRL: ctrl_r <= i_avs_writedata[1:0];
				OFS_CFG: begin
					bars_r <= i_avs_writedata[CFG_BARS_LSB +: 2];
					blk_r <= i_avs_writedata[CFG_BLK_LSB +: 4];
				end
				OFS_CSI: csi_r <= i_avs_writedata[7:0];
				OFS_LINE_SIZE: lsize_r <= merge16(lsize_r, i_avs_writedata,
					i_avs_byteenable);
				OFS_BAR_SIZE: bar_r <= merge16(bar_r, i_avs_writedata,
					i_avs_byteenable);
				OFS_ACT_LINES: act_r <= merge16(act_r, i_avs_writedata,
					i_avs_byteenable);
				OFS_TOT_LINES: tot_r <= merge16(tot_r, i_avs_writedata,
					i_avs_byteenable);
				OFS_LINE_PD: pd_r <= merge16(pd_r, i_avs_writedata,
					i_avs_byteenable);
				OFS_VBP: vbp_r <= i_avs_writedata[7:0];
				OFS_VFP: vfp_r <= i_avs_writedata[7:0];
				default: ;
			endcase
		end else if (wr_do && !fix_sel && i_avs_byteenable[1]) begin
			unique case (i_avs_address)
				OFS_LINE_SIZE: lsize_r[15:8] <= i_avs_writedata[15:8];
				OFS_BAR_SIZE: bar_r[15:8] <= i_avs_writedata[15:8];
				OFS_ACT_LINES: act_r[15:8] <= i_avs_writedata[15:8];
				OFS_TOT_LINES: tot_r[15:8] <= i_avs_writedata[15:8];
				OFS_LINE_PD: pd_r[15:8] <= i_avs_writedata[15:8];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < FIX_BYTES; i++) begin
				fix_r[i] <= BYTE_RST;
			end
		end else if (wr_do && fix_sel && i_avs_byteenable[0]) begin
			fix_r[fix_idx] <= i_avs_writedata[7:0];
		end
	end

	// frame geometry
	assign running = state_r != S_IDLE;
	assign pd_limit = PD_W'(sh_pd * UNIT_CYC);
	assign pd_cnt_p1 = pd_cnt_r + PD_W'(1);
	assign tick = running & (pd_cnt_p1 >= pd_limit);
	assign act_end = 16'({8'h0, sh_vbp} + sh_act);
	assign fe_slot = 16'(act_end + {8'h0, sh_vfp});
	assign line_active = line_idx_r >= {8'h0, sh_vbp}
		&& line_idx_r < act_end;
	assign line_is_fe = line_idx_r == fe_slot;
	assign line_next = (line_idx_r + 16'h1 >= sh_tot) ? 16'h0
		: 16'(line_idx_r + 16'h1);
	assign frame_start = i_ce & ctrl_r[CTRL_EN_BIT]
		& (state_r == S_IDLE | (state_r == S_WAIT & pend_r
		& line_idx_r == 16'h0));
	assign can_load = ~o_tx_valid | i_tx_ready;
	assign load = i_ce & can_load & emit;

	// pattern byte
	assign last_byte = byte_cnt_r + 16'h1 >= sh_lsize;
	assign bar_end = bar_pos_r + 16'h1 >= sh_bar
		&& bar_idx_r != bars_m1(sh_bars);
	assign blk_end = blk_idx_r == sh_blk;
	assign pat_byte = sh_fixed
		? sh_fix[blk_idx_r] ^ {8{bar_idx_r[0]}}
		: BAR_TABLE[{bar_idx_r, 3'h0} +: 8];

	always_comb begin
		emit = 1'b0;
		emit_kind = K_FS;
		emit_data = 16'h0;
		emit_last = 1'b0;
		unique case (state_r)
			S_FS: emit = 1'b1;
			S_FE: begin
				emit = 1'b1;
				emit_kind = K_FE;
			end
			S_HDR: begin
				emit = 1'b1;
				emit_kind = K_HDR;
				emit_data = sh_lsize;
			end
			S_DATA: begin
				emit = 1'b1;
				emit_kind = K_BYTE;
				emit_data = {8'h0, pat_byte};
				emit_last = last_byte;
			end
			S_IDLE, S_LINE, S_WAIT: ;
		endcase
	end

	// shadows captured only when a frame begins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sh_fixed <= 1'b0;
			sh_bars <= BARS_RST;
			sh_blk <= BLK_RST;
			sh_csi <= CSI_RST;
			sh_lsize <= WORD16_RST;
			sh_bar <= WORD16_RST;
			sh_act <= WORD16_RST;
			sh_tot <= WORD16_RST;
			sh_pd <= WORD16_RST;
			sh_vbp <= BYTE_RST;
			sh_vfp <= BYTE_RST;
			for (int i = 0; i < FIX_BYTES; i++) begin
				sh_fix[i] <= BYTE_RST;
			end
		end else if (frame_start) begin
			sh_fixed <= ctrl_r[CTRL_FIXED_BIT];
			sh_bars <= bars_r;
			sh_blk <= blk_r;
			sh_csi <= csi_r;
			sh_lsize <= lsize_r;
			sh_bar <= bar_r;
			sh_act <= act_r;
			sh_tot <= tot_r;
			sh_pd <= pd_r;
			sh_vbp <= vbp_r;
			sh_vfp <= vfp_r;
			sh_fix <= fix_r;
		end
	end

	// line period timer and slot index
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pd_cnt_r <= '0;
			line_idx_r <= 16'h0;
			pend_r <= 1'b0;
		end else if (i_ce) begin
			if (frame_start && state_r == S_IDLE) begin
				// slot 0 dispatched like any later wrap
				pd_cnt_r <= '0;
				line_idx_r <= 16'h0;
				pend_r <= 1'b1;
			end else if (!running) begin
				pend_r <= 1'b0;
			end else begin
				pd_cnt_r <= tick ? '0 : pd_cnt_p1;
				if (tick) begin
					line_idx_r <= line_next;
				end
				if (tick) begin
					pend_r <= 1'b1;
				end else if (state_r == S_WAIT) begin
					pend_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r <= S_IDLE;
		end else if (i_ce) begin
			unique case (state_r)
				S_IDLE: if (frame_start) state_r <= S_WAIT;
				S_FS: if (load) state_r <= S_LINE;
				S_LINE: begin
					if (line_active) begin
						state_r <= S_HDR;
					end else if (line_is_fe) begin
						state_r <= S_FE;
					end else begin
						state_r <= S_WAIT;
					end
				end
				S_HDR: begin
					if (load) begin
						state_r <= (sh_lsize == 16'h0) ? S_WAIT : S_DATA;
					end
				end
				S_DATA: if (load && last_byte) state_r <= S_WAIT;
				S_FE: if (load) state_r <= S_WAIT;
				S_WAIT: begin
					if (pend_r && line_idx_r == 16'h0) begin
						state_r <= frame_start ? S_FS : S_IDLE;
					end else if (pend_r) begin
						state_r <= S_LINE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			byte_cnt_r <= 16'h0;
			bar_pos_r <= 16'h0;
			bar_idx_r <= 3'h0;
			blk_idx_r <= 4'h0;
		end else if (load && state_r == S_HDR) begin
			byte_cnt_r <= 16'h0;
			bar_pos_r <= 16'h0;
			bar_idx_r <= 3'h0;
			blk_idx_r <= 4'h0;
		end else if (load && state_r == S_DATA) begin
			byte_cnt_r <= 16'(byte_cnt_r + 16'h1);
			blk_idx_r <= blk_end ? 4'h0 : 4'(blk_idx_r + 4'h1);
			if (bar_end) begin
				bar_pos_r <= 16'h0;
				bar_idx_r <= 3'(bar_idx_r + 3'h1);
			end else begin
				bar_pos_r <= 16'(bar_pos_r + 16'h1);
			end
		end
	end

	// registered stream outputs, same clock as the transmitter
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_tx_valid <= 1'b0;
			o_tx_kind <= K_FS;
			o_tx_data <= 16'h0;
			o_tx_dt <= 6'h0;
			o_tx_vc <= 2'h0;
			o_tx_last <= 1'b0;
		end else if (i_ce && can_load) begin
			o_tx_valid <= emit;
			if (emit) begin
				o_tx_kind <= emit_kind;
				o_tx_data <= emit_data;
				o_tx_dt <= sh_csi[CSI_DT_LSB +: 6];
				o_tx_vc <= sh_csi[CSI_VC_LSB +: 2];
				o_tx_last <= emit_last;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_fs_load;
		i_ce && state_r == S_FS && can_load;
	endsequence
	sequence s_fs_out;
		o_tx_valid && o_tx_kind == K_FS ##1 state_r != S_FS;
	endsequence

	property p_fs_first;
		s_fs_load |=> s_fs_out;
	endproperty
	a_fs_first: assert property (p_fs_first)
		else $error("frame start not emitted");

	property p_last_pos;
		load && emit_kind == K_BYTE && emit_last
			|-> byte_cnt_r == 16'(sh_lsize - 16'h1);
	endproperty
	a_last_pos: assert property (p_last_pos)
		else $error("line ended at wrong byte");

	property p_bar_bound;
		state_r == S_DATA |-> bar_idx_r <= bars_m1(sh_bars);
	endproperty
	a_bar_bound: assert property (p_bar_bound)
		else $error("bar index beyond bar count");

	property p_bar_byte;
		load && emit_kind == K_BYTE && !sh_fixed
			|=> o_tx_data[7:0] == BAR_TABLE[{$past(bar_idx_r), 3'h0} +: 8];
	endproperty
	a_bar_byte: assert property (p_bar_byte)
		else $error("wrong color bar byte");

	property p_blk_bound;
		state_r == S_DATA |-> blk_idx_r <= sh_blk;
	endproperty
	a_blk_bound: assert property (p_blk_bound)
		else $error("block index beyond block length");

	property p_period;
		i_ce && tick |=> pd_cnt_r == '0 ##1 (!i_ce || pd_cnt_r != '0
			|| pd_limit <= PD_W'(1));
	endproperty
	a_period: assert property (p_period)
		else $error("line period counter wrong");

	property p_wrap;
		i_ce && tick && line_idx_r + 16'h1 >= sh_tot
			|=> line_idx_r == 16'h0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("frame did not wrap at total lines");

	property p_shadow;
		i_ce && running && !frame_start |=> $stable(sh_lsize)
			&& $stable(sh_csi);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("settings changed inside a frame");

	property p_active_slot;
		state_r == S_HDR |-> line_idx_r >= {8'h0, sh_vbp}
			&& line_idx_r < act_end;
	endproperty
	a_active_slot: assert property (p_active_slot)
		else $error("active line outside active slots");

	property p_fe_slot;
		state_r == S_FE |-> line_idx_r == fe_slot;
	endproperty
	a_fe_slot: assert property (p_fe_slot)
		else $error("frame end in wrong slot");
endmodule : csi2_test_pattern_generator

/* pattern_gen_pkg.sv */
package pattern_gen_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_CSI = 8'h08;
	localparam logic [7:0] OFS_LINE_SIZE = 8'h0c;
	localparam logic [7:0] OFS_BAR_SIZE = 8'h10;
	localparam logic [7:0] OFS_ACT_LINES = 8'h14;
	localparam logic [7:0] OFS_TOT_LINES = 8'h18;
	localparam logic [7:0] OFS_LINE_PD = 8'h1c;
	localparam logic [7:0] OFS_VBP = 8'h20;
	localparam logic [7:0] OFS_VFP = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	// fixed pattern bytes: one word each from this base
	localparam logic [1:0] FIX_PAGE = 2'h1;
	localparam int FIX_BYTES = 16;
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FIXED_BIT = 1;
	localparam int CFG_BARS_LSB = 0;
	localparam int CFG_BLK_LSB = 4;
	localparam int CSI_DT_LSB = 0;
	localparam int CSI_VC_LSB = 6;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_FRAME_BIT = 1;
	localparam int STAT_LINE_LSB = 16;
	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [1:0] BARS_RST = 2'h3;
	localparam logic [3:0] BLK_RST = 4'h0;
	localparam logic [7:0] CSI_RST = 8'h00;
	localparam logic [15:0] WORD16_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// reference bar bytes, bar 0 in the low byte
	localparam logic [63:0] BAR_TABLE = 64'h800fcc557ff033aa;
	// output item kinds
	localparam logic [1:0] K_FS = 2'h0;
	localparam logic [1:0] K_FE = 2'h1;
	localparam logic [1:0] K_HDR = 2'h2;
	localparam logic [1:0] K_BYTE = 2'h3;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINE_UNIT_NS = 10;
	localparam int UNIT_CYC = (LINE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_W = 24;
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_FS = 7'b0000010,
		S_LINE = 7'b0000100,
		S_HDR = 7'b0001000,
		S_DATA = 7'b0010000,
		S_FE = 7'b0100000,
		S_WAIT = 7'b1000000
	} state_e;
endpackage : pattern_gen_pkg

/* tb_csi2_test_pattern_generator.sv */
`timescale 1ns/100ps
module tb_csi2_test_pattern_generator;
	import pattern_gen_pkg::*;
	localparam int PD = 40;
	localparam logic [5:0] DT = 6'h24;
	localparam logic [1:0] VC = 2'h1;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic rdy;
	logic vld;
	logic lst;
	logic slow = 1'b0;
	logic [1:0] kind;
	logic [1:0] vc;
	logic [15:0] dat;
	logic [5:0] dt;
	int fails = 0;
	int tests_run = 0;
	int ls, bs, act, vbp, vfp, tot, blk;
	logic [7:0] fixb[16];
	logic [7:0] bars[8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc,
		8'h0f, 8'h80};

	always #5 clk = ~clk;

	csi2_test_pattern_generator dut_u (
		.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
		.i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en),
		.i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_tx_ready(rdy), .o_tx_valid(vld), .o_tx_kind(kind),
		.o_tx_data(dat), .o_tx_dt(dt), .o_tx_vc(vc), .o_tx_last(lst)
	);

	tx_sink rx_u (
		.i_clk(clk), .i_sys_rst(rst), .i_slow(slow), .i_valid(vld),
		.i_kind(kind), .i_data(dat), .i_dt(dt), .i_vc(vc), .i_last(lst),
		.o_ready(rdy)
	);

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic tally(input logic ok, input string msg);
		tests_run++;
		if (!ok) begin
			fails++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : tally

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] e);
		tally(got === e, $sformatf("value %h expected %h", got, e));
	endtask : cmp_reg

	task automatic cmp_item(input int k, input logic [26:0] e);
		logic [26:0] got;
		got = (k < rx_u.items.size()) ? rx_u.items[k] : 'x;
		tally(got === e, $sformatf("item %0d %h expected %h", k, got, e));
	endtask : cmp_item

	task automatic cmp_gap(input int got, input int e);
		tally(got == e, $sformatf("gap %0d expected %0d", got, e));
	endtask : cmp_gap

	// holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		if (w) wr_en <= 1'b1;
		else rd_en <= 1'b1;
		// waitrequest and readdata seen as sampled at the edge
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		if (n >= 100) tally(1'b0, "bus stuck");
		q = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp_reg(q, e);
	endtask : rd

	function automatic logic [26:0] it(input logic l, input logic [1:0] k,
			input logic [15:0] d);
		return {l, VC, DT, k, d};
	endfunction : it

	// expected byte at a line position: last bar takes the leftover
	function automatic logic [7:0] eb(input int p, input logic [1:0] code,
			input logic fx);
		int b;
		b = p / bs;
		if (b > (1 << code) - 1) b = (1 << code) - 1;
		if (!fx) return bars[b];
		return b[0] ? ~fixb[p % blk] : fixb[p % blk];
	endfunction : eb

	task automatic frame(input logic [1:0] code, input logic fx,
			input int nf, input logic poke);
		int n, k, t;
		wr(OFS_CFG, {24'h0, 4'(blk - 1), 2'h0, code});
		wr(OFS_CSI, {24'h0, VC, DT});
		wr(OFS_LINE_SIZE, 32'(ls));
		wr(OFS_BAR_SIZE, 32'(bs));
		wr(OFS_ACT_LINES, 32'(act));
		wr(OFS_TOT_LINES, 32'(tot));
		wr(OFS_LINE_PD, 32'(PD));
		wr(OFS_VBP, 32'(vbp));
		wr(OFS_VFP, 32'(vfp));
		for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), {24'h0, fixb[i]});
		rx_u.items.delete();
		rx_u.stamps.delete();
		slow <= fx;
		wr(OFS_CTRL, {30'h0, fx, 1'b1});
		n = 2 + act * (ls + 1);
		t = 0;
		while (rx_u.items.size() < n * nf && t < 20000) begin
			@(posedge clk);
			t++;
			if (poke && t == 5) wr(OFS_LINE_SIZE, 32'(ls + 3));
		end
		wr(OFS_CTRL, 32'h0);
		repeat (2 * tot * PD) @(posedge clk);
		cmp_reg(32'(rx_u.items.size()), 32'(n * nf));
		k = 0;
		for (int f = 0; f < nf; f++) begin
			cmp_item(k++, it(1'b0, K_FS, 16'h0));
			for (int l = 0; l < act; l++) begin
				cmp_item(k++, it(1'b0, K_HDR, 16'(ls)));
				for (int p = 0; p < ls; p++)
					cmp_item(k++, it(p == ls - 1, K_BYTE,
						{8'h0, eb(p, code, fx)}));
			end
			cmp_item(k++, it(1'b0, K_FE, 16'h0));
		end
		if (nf == 2) begin
			cmp_gap(rx_u.stamps[ls + 2] - rx_u.stamps[1],
				PD * UNIT_CYC);
			cmp_gap(rx_u.stamps[n - 1] - rx_u.stamps[n - 2 - ls],
				(vfp + 1) * PD * UNIT_CYC);
			cmp_gap(rx_u.stamps[n] - rx_u.stamps[0],
				tot * PD * UNIT_CYC);
		end
	endtask : frame

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	initial begin
		foreach (fixb[i]) fixb[i] = 8'h00;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_CFG, 32'h3);
		rd(OFS_LINE_SIZE, 32'h0);
		rd(OFS_STATUS, 32'h0);
		wr(8'h30, 32'hffff_ffff);
		rd(8'h30, 32'h0);
		wr(8'h7c, 32'ha5);
		rd(8'h7c, 32'ha5);
		ls = 20; bs = 2; act = 2; vbp = 1; vfp = 1; tot = 6; blk = 1;
		frame(2'h3, 1'b0, 2, 1'b0);
		ls = 9; act = 1; vbp = 0; vfp = 0; tot = 3;
		for (int c = 0; c < 3; c++) frame(2'(c), 1'b0, 1, 1'b0);
		fixb[0] = 8'h11; fixb[1] = 8'h22; fixb[2] = 8'h33;
		ls = 8; bs = 3; blk = 3;
		frame(2'h1, 1'b1, 1, 1'b1);
		close_out();
	end
endmodule : tb_csi2_test_pattern_generator

/* tx_sink.sv */
`timescale 1ns/100ps
module tx_sink (
	// clock, reset and slow-mode select
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_slow,
	// stream from the generator
	input wire logic i_valid,
	input wire logic [1:0] i_kind,
	input wire logic [15:0] i_data,
	input wire logic [5:0] i_dt,
	input wire logic [1:0] i_vc,
	input wire logic i_last,
	output logic o_ready
);
	logic [26:0] items[$];
	int stamps[$];
	int cyc_r = 0;
	logic [1:0] ph_r = 2'h0;
	// slow mode accepts one cycle in three
	assign o_ready = !i_slow || (ph_r == 2'h0);
	always_ff @(posedge i_clk) begin
		cyc_r <= cyc_r + 1;
		ph_r <= (ph_r == 2'h2 || i_sys_rst) ? 2'h0 : ph_r + 2'h1;
	end
	// each item taken whole at acceptance, straight off the port
	always_ff @(posedge i_clk) begin
		if (i_valid && o_ready && !i_sys_rst) begin
			items.push_back({i_last, i_vc, i_dt, i_kind, i_data});
			stamps.push_back(cyc_r);
		end
	end
endmodule : tx_sink
